// ### inc/pixel_datapath_pkg.sv
// Package with register indices, field positions and reset values of the pixel datapath.
`default_nettype none
package pixel_datapath_pkg;
    // ---------------------------------------------------------------
    // Register indices behind the data port.
    // ---------------------------------------------------------------
    localparam logic [3:0] IDX_SR_VALUE = 4'h0; // Plane set/reset value.
    localparam logic [3:0] IDX_SR_ENABLE = 4'h1; // Plane set/reset enable.
    localparam logic [3:0] IDX_CMP_COLOR = 4'h2; // Compare reference color.
    localparam logic [3:0] IDX_ROT_FUNC = 4'h3; // Rotate count and function.
    localparam logic [3:0] IDX_PLANE_SEL = 4'h4; // Read plane select.
    localparam logic [3:0] IDX_MODE = 4'h5; // Write and read mode control.
    localparam logic [3:0] IDX_MISC = 4'h6; // Memory map miscellany.
    localparam logic [3:0] IDX_CMP_IGNORE = 4'h7; // Compare plane ignore.
    localparam logic [3:0] IDX_BIT_MASK = 4'h8; // Pixel write mask.
    // Index of the latch readback register in the timing-controller space.
    localparam logic [7:0] IDX_LATCH_READBACK = 8'h22;
    // ---------------------------------------------------------------
    // Implemented bits of each register; the rest read as zero.
    // ---------------------------------------------------------------
    localparam logic [7:0] MASK_NIBBLE = 8'h0F; // Registers with bits 3-0 only.
    localparam logic [7:0] MASK_ROT_FUNC = 8'h1F; // Bits 4-0.
    localparam logic [7:0] MASK_PLANE_SEL = 8'h03; // Bits 1-0.
    localparam logic [7:0] MASK_MODE = 8'h7B; // Bits 6-3 and 1-0.
    localparam logic [7:0] MASK_INDEX = 8'h0F; // Bits 3-0 of the index.
    // ---------------------------------------------------------------
    // Field positions.
    // ---------------------------------------------------------------
    localparam int ROT_CNT_LSB = 0; // Rotate count, 3 bits.
    localparam int FUNC_LSB = 3; // Logical function, 2 bits.
    localparam int WMODE_LSB = 0; // Write mode, 2 bits.
    localparam int RMODE_BIT = 3; // Read mode bit.
    localparam int ODD_EVEN_BIT = 4; // Odd/even addressing bit.
    // Value of every register after reset.
    localparam logic [7:0] REG_RESET = 8'h00;
    // ---------------------------------------------------------------
    // Encodings.
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        WMODE_ROTATE = 2'b00,
        WMODE_LATCH = 2'b01,
        WMODE_COLOR = 2'b10,
        WMODE_PATTERN = 2'b11
    } write_mode_e;
    typedef enum logic [1:0] {
        FUNC_PASS = 2'b00,
        FUNC_AND = 2'b01,
        FUNC_OR = 2'b10,
        FUNC_XOR = 2'b11
    } logic_func_e;
endpackage
`default_nettype wire

// ### rtl/planar_pixel_datapath.sv
// Planar pixel write/read datapath between host accesses and four display memory planes.
//
// Notes on behaviour
// - Four-bit index selects register behind data port.
// - Two-bit write mode; byte lanes processed separately.
// - Mode 0 writes rotated byte to planes.
// - Mode 0 enabled planes take set/reset value.
// - Set/reset bit replicated across whole byte.
// - Host data rotated right by count.
// - Function: pass, AND, OR, XOR with latches.
// - Mode 1 writes latch contents to planes.
// - Every memory read reloads plane latches.
// - Mode 2 host nibble is color per plane.
// - Mode 3 rotated data ANDed with mask.
// - Read mode 1 returns per-pixel color match.
// - Plane selector chooses plane, addressing overrides.
// - Latch readback register at timing index.
// - Read mode bit picks plane or compare.
// - Ignore bit zero excludes plane from compare.
// - Bit mask one passes, zero keeps latch.
`default_nettype none
module planar_pixel_datapath (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Host I/O port pair: port 0 is the index, port 1 the data.
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic io_port_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    input wire logic group1_protect_in,
    // Timing-controller index space readback.
    input wire logic [7:0] crtc_index_in,
    output logic [7:0] crtc_rdata_out,
    // Host display memory access.
    input wire logic mem_rd_in,
    input wire logic mem_wr_in,
    input wire logic [1:0] host_addr_in,
    input wire logic quad_mode_in,
    input wire logic [15:0] host_wdata_in,
    output logic [15:0] host_rdata_out,
    // Display memory planes: lane l, plane p at bits l*32+p*8.
    input wire logic [63:0] mem_rdata_in,
    output logic plane_wr_out,
    output logic [63:0] plane_wdata_out
);
    // ---------------------------------------------------------------
    // Register storage.
    // ---------------------------------------------------------------
    logic [3:0] index_q; // Selected register.
    logic [3:0] sr_value_q; // Set/reset color.
    logic [3:0] sr_enable_q; // Set/reset enables.
    logic [3:0] cmp_color_q; // Compare reference color.
    logic [4:0] rot_func_q; // Function and rotate count.
    logic [1:0] plane_sel_q; // Read plane selector.
    logic [7:0] mode_q; // Mode control, reserved bits held zero.
    logic [3:0] misc_q; // Memory map bits, stored only.
    logic [3:0] cmp_ignore_q; // Compare plane include bits.
    logic [7:0] bit_mask_q; // Pixel write mask.
    logic [63:0] latch_q; // Plane data latches, both lanes.
    logic [7:0] io_rdata_q;
    logic [7:0] crtc_rdata_q;
    logic [15:0] host_rdata_q;
    logic plane_wr_q;
    logic [63:0] plane_wdata_q;

    // Decoded controls.
    wire logic reg_wr = io_wr_in && !group1_protect_in;
    wire logic index_wr = reg_wr && !io_port_in;
    wire logic data_wr = reg_wr && io_port_in;
    wire logic [1:0] write_mode = mode_q[WMODE_LSB +: 2];
    wire logic read_mode = mode_q[RMODE_BIT];
    wire logic odd_even = mode_q[ODD_EVEN_BIT];
    wire logic [2:0] rot_cnt = rot_func_q[ROT_CNT_LSB +: 3];
    wire logic [1:0] func_sel = rot_func_q[FUNC_LSB +: 2];
    wire logic [7:0] latch_pick = latch_q[{3'h0, plane_sel_q} * 8 +: 8];

    localparam int WMODE_LSB = pixel_datapath_pkg::WMODE_LSB;
    localparam int RMODE_BIT = pixel_datapath_pkg::RMODE_BIT;
    localparam int ODD_EVEN_BIT = pixel_datapath_pkg::ODD_EVEN_BIT;
    localparam int ROT_CNT_LSB = pixel_datapath_pkg::ROT_CNT_LSB;
    localparam int FUNC_LSB = pixel_datapath_pkg::FUNC_LSB;

    // Plane chosen for plane-select reads; addressing modes override the selector.
    wire logic [1:0] read_plane = quad_mode_in ? host_addr_in :
        (odd_even ? {plane_sel_q[1], host_addr_in[0]} : plane_sel_q);

    // ---------------------------------------------------------------
    // Functions.
    // ---------------------------------------------------------------
    // Builds the four plane bytes written for one host byte.
    function automatic logic [31:0] write_lane(input logic [7:0] d, input logic [31:0] lat);
        logic [7:0] rot;
        logic [7:0] src;
        logic [7:0] alu;
        logic [7:0] msk;
        logic [31:0] res;
        rot = 8'h00;
        src = 8'h00;
        alu = 8'h00;
        msk = 8'h00;
        res = 32'h0000_0000;
        // Right rotation by the programmed count.
        rot = 8'((({d, d}) >> rot_cnt));
        // Pattern mode masks with rotated data; all others use the mask alone.
        msk = (write_mode == pixel_datapath_pkg::WMODE_PATTERN) ? (rot & bit_mask_q)
            : bit_mask_q;
        for (int p = 0; p < 4; p++) begin
            case (write_mode)
                pixel_datapath_pkg::WMODE_ROTATE: begin
                    // Enabled planes take the replicated set/reset bit.
                    src = sr_enable_q[p] ? {8{sr_value_q[p]}} : rot;
                end
                pixel_datapath_pkg::WMODE_COLOR: begin
                    // Host nibble gives each plane its color bit.
                    src = {8{d[p]}};
                end
                pixel_datapath_pkg::WMODE_PATTERN: begin
                    // Set/reset color, enables ignored.
                    src = {8{sr_value_q[p]}};
                end
                default: begin
                    // Latch copy mode ignores host data.
                    src = lat[p*8 +: 8];
                end
            endcase
            case (func_sel)
                pixel_datapath_pkg::FUNC_AND: alu = src & lat[p*8 +: 8];
                pixel_datapath_pkg::FUNC_OR: alu = src | lat[p*8 +: 8];
                pixel_datapath_pkg::FUNC_XOR: alu = src ^ lat[p*8 +: 8];
                default: alu = src;
            endcase
            if (write_mode == pixel_datapath_pkg::WMODE_LATCH) begin
                alu = lat[p*8 +: 8];
            end
            // Mask merge with the latches is the final step.
            res[p*8 +: 8] = (alu & msk) | (lat[p*8 +: 8] & ~msk);
        end
        return res;
    endfunction

    // Returns one host byte read from the four plane bytes of a lane.
    function automatic logic [7:0] read_lane(input logic [31:0] m);
        logic [7:0] r;
        logic [3:0] px;
        r = 8'h00;
        px = 4'h0;
        if (read_mode) begin
            // Compare each pixel over the included planes.
            for (int i = 0; i < 8; i++) begin
                px = {m[24+i], m[16+i], m[8+i], m[i]};
                r[i] = ~|((px ^ cmp_color_q) & cmp_ignore_q);
            end
        end else begin
            r = m[{3'h0, read_plane} * 8 +: 8];
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // Register writes.
    // ---------------------------------------------------------------
    // Index and data port writes; reserved bits are never stored.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            index_q <= 4'h0;
            sr_value_q <= 4'h0;
            sr_enable_q <= 4'h0;
            cmp_color_q <= 4'h0;
            rot_func_q <= 5'h00;
            plane_sel_q <= 2'h0;
            mode_q <= pixel_datapath_pkg::REG_RESET;
            misc_q <= 4'h0;
            cmp_ignore_q <= 4'h0;
            bit_mask_q <= pixel_datapath_pkg::REG_RESET;
        end else if (index_wr) begin
            index_q <= io_wdata_in[3:0];
        end else if (data_wr) begin
            case (index_q)
                pixel_datapath_pkg::IDX_SR_VALUE: sr_value_q <= io_wdata_in[3:0];
                pixel_datapath_pkg::IDX_SR_ENABLE: sr_enable_q <= io_wdata_in[3:0];
                pixel_datapath_pkg::IDX_CMP_COLOR: cmp_color_q <= io_wdata_in[3:0];
                pixel_datapath_pkg::IDX_ROT_FUNC: rot_func_q <= io_wdata_in[4:0];
                pixel_datapath_pkg::IDX_PLANE_SEL: plane_sel_q <= io_wdata_in[1:0];
                pixel_datapath_pkg::IDX_MODE: mode_q <= io_wdata_in & pixel_datapath_pkg::MASK_MODE;
                pixel_datapath_pkg::IDX_MISC: misc_q <= io_wdata_in[3:0];
                pixel_datapath_pkg::IDX_CMP_IGNORE: cmp_ignore_q <= io_wdata_in[3:0];
                pixel_datapath_pkg::IDX_BIT_MASK: bit_mask_q <= io_wdata_in;
                default: begin
                    // Unused indices take no write.
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Register reads.
    // ---------------------------------------------------------------
    // Read value of the register at the current index, upper bits zero.
    wire logic [7:0] data_rd_value =
        (index_q == pixel_datapath_pkg::IDX_SR_VALUE) ? {4'h0, sr_value_q} :
        (index_q == pixel_datapath_pkg::IDX_SR_ENABLE) ? {4'h0, sr_enable_q} :
        (index_q == pixel_datapath_pkg::IDX_CMP_COLOR) ? {4'h0, cmp_color_q} :
        (index_q == pixel_datapath_pkg::IDX_ROT_FUNC) ? {3'h0, rot_func_q} :
        (index_q == pixel_datapath_pkg::IDX_PLANE_SEL) ? {6'h00, plane_sel_q} :
        (index_q == pixel_datapath_pkg::IDX_MODE) ? mode_q :
        (index_q == pixel_datapath_pkg::IDX_MISC) ? {4'h0, misc_q} :
        (index_q == pixel_datapath_pkg::IDX_CMP_IGNORE) ? {4'h0, cmp_ignore_q} :
        (index_q == pixel_datapath_pkg::IDX_BIT_MASK) ? bit_mask_q : 8'h00;

    // Captures I/O read data and the latch readback one cycle after the request.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            io_rdata_q <= 8'h00;
            crtc_rdata_q <= 8'h00;
        end else begin
            if (io_rd_in) begin
                io_rdata_q <= io_port_in ? data_rd_value : {4'h0, index_q};
            end
            // Readback holds zero for any other timing index.
            crtc_rdata_q <= (crtc_index_in == pixel_datapath_pkg::IDX_LATCH_READBACK)
                ? latch_pick : 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // Memory datapath.
    // ---------------------------------------------------------------
    // Latches reload on every memory read; writes and reads produce lane results.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            latch_q <= 64'h0000_0000_0000_0000;
            host_rdata_q <= 16'h0000;
            plane_wr_q <= 1'b0;
            plane_wdata_q <= 64'h0000_0000_0000_0000;
        end else begin
            plane_wr_q <= mem_wr_in;
            if (mem_rd_in) begin
                latch_q <= mem_rdata_in;
                host_rdata_q <= {read_lane(mem_rdata_in[63:32]), read_lane(mem_rdata_in[31:0])};
            end
            if (mem_wr_in) begin
                plane_wdata_q <= {write_lane(host_wdata_in[15:8], latch_q[63:32]),
                    write_lane(host_wdata_in[7:0], latch_q[31:0])};
            end
        end
    end

    // Outputs.
    assign io_rdata_out = io_rdata_q;
    assign crtc_rdata_out = crtc_rdata_q;
    assign host_rdata_out = host_rdata_q;
    assign plane_wr_out = plane_wr_q;
    assign plane_wdata_out = plane_wdata_q;

    // ---------------------------------------------------------------
    // Assertions.
    // ---------------------------------------------------------------
    property p_index_write;
        @(posedge core_clk_in) disable iff (rst_in)
        (io_wr_in && !io_port_in && !group1_protect_in) |=> index_q == $past(io_wdata_in[3:0]);
    endproperty
    a_index_write: assert property (p_index_write) else $error("Index not taken.");

    property p_protect;
        @(posedge core_clk_in) disable iff (rst_in)
        (io_wr_in && group1_protect_in) |=> ($stable(bit_mask_q) && $stable(index_q));
    endproperty
    a_protect: assert property (p_protect) else $error("Protected write changed state.");

    property p_latch_load;
        @(posedge core_clk_in) disable iff (rst_in)
        mem_rd_in |=> latch_q == $past(mem_rdata_in);
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("Latches not reloaded.");

    property p_latch_copy;
        @(posedge core_clk_in) disable iff (rst_in)
        (mem_wr_in && write_mode == pixel_datapath_pkg::WMODE_LATCH && !mem_rd_in)
        |=> plane_wr_out && plane_wdata_out == latch_q;
    endproperty
    a_latch_copy: assert property (p_latch_copy) else $error("Latch copy wrong.");

    property p_mask_keep;
        @(posedge core_clk_in) disable iff (rst_in)
        (mem_wr_in && write_mode != pixel_datapath_pkg::WMODE_PATTERN)
        |=> ((plane_wdata_out ^ $past(latch_q)) & ~{8{$past(bit_mask_q)}}) == 64'h0;
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("Masked bit not kept.");

    property p_reserved;
        @(posedge core_clk_in) disable iff (rst_in)
        (io_rd_in && io_port_in && index_q == pixel_datapath_pkg::IDX_SR_VALUE)
        |=> io_rdata_out[7:4] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bits not zero.");

    property p_readback;
        @(posedge core_clk_in) disable iff (rst_in)
        (crtc_index_in == pixel_datapath_pkg::IDX_LATCH_READBACK) |=> crtc_rdata_out == $past(latch_pick);
    endproperty
    a_readback: assert property (p_readback) else $error("Latch readback wrong.");

    property p_compare_all;
        @(posedge core_clk_in) disable iff (rst_in)
        (mem_rd_in && read_mode && cmp_ignore_q == 4'h0) |=> host_rdata_out == 16'hFFFF;
    endproperty
    a_compare_all: assert property (p_compare_all) else $error("Compare ignore fault.");

    property p_no_write;
        @(posedge core_clk_in) disable iff (rst_in)
        !mem_wr_in |=> !plane_wr_out ##1 (plane_wr_out == $past(mem_wr_in));
    endproperty
    a_no_write: assert property (p_no_write) else $error("Spurious plane write.");
endmodule
`default_nettype wire

// ### verif/plane_memory_model.sv
// Behavioural model of the display memory planes at the datapath's far side.
`default_nettype none
module plane_memory_model (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Plane write port driven by the datapath.
    input wire logic plane_wr_in,
    input wire logic [63:0] plane_wdata_in,
    // Bench-side preload of the stored word.
    input wire logic fill_en_in,
    input wire logic [63:0] fill_data_in,
    // Read data seen by the datapath.
    output logic [63:0] mem_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] store_q; // One addressed byte of every plane in both lanes.
    // The stored word is preloaded by the bench or taken from a plane write.
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            store_q <= 64'h0;
        end else if (fill_en_in) begin
            store_q <= fill_data_in;
        end else if (plane_wr_in) begin
            store_q <= plane_wdata_in;
        end
    end
    // Memory answers at once, so reads never wait.
    assign mem_rdata_out = store_q;
endmodule
`default_nettype wire

// ### verif/test_planar_pixel_datapath.sv
// Self-checking random testbench for the planar pixel datapath.
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module test_planar_pixel_datapath;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Signals and bench state.
    // ----------------------------------------------------------------
    logic core_clk_in = 1'b0, rst_in = 1'b1, io_wr = 1'b0, io_rd = 1'b0, io_port = 1'b0;
    logic [7:0] io_wdata = 8'h00, io_rdata, crtc_idx = 8'h00, crtc_rdata;
    logic protect = 1'b0, mem_rd = 1'b0, mem_wr = 1'b0, quad = 1'b0, pwr, fill_en = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [15:0] hwdata = 16'h0000, hrdata;
    logic [63:0] mrdata, pwdata, lat = 64'h0;
    logic [7:0] regs [0:15]; // Expected register contents.
    logic [7:0] v;
    int seed = 36, num_errors = 0, n_compared = 0, cycles = 0;
    // ----------------------------------------------------------------
    // Design, memory model and clock.
    // ----------------------------------------------------------------
    planar_pixel_datapath u_planar_pixel_datapath (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .io_wr_in(io_wr), .io_rd_in(io_rd), .io_port_in(io_port), .io_wdata_in(io_wdata),
        .io_rdata_out(io_rdata), .group1_protect_in(protect), .crtc_index_in(crtc_idx),
        .crtc_rdata_out(crtc_rdata), .mem_rd_in(mem_rd), .mem_wr_in(mem_wr),
        .host_addr_in(addr), .quad_mode_in(quad), .host_wdata_in(hwdata),
        .host_rdata_out(hrdata), .mem_rdata_in(mrdata), .plane_wr_out(pwr),
        .plane_wdata_out(pwdata));
    plane_memory_model u_plane_memory_model (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .plane_wr_in(pwr), .plane_wdata_in(pwdata), .fill_en_in(fill_en),
        .fill_data_in(lat), .mem_rdata_out(mrdata));
    always #20 core_clk_in = ~core_clk_in;
    // A hung run is cut short and reported as failing.
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_of_test();
        end
    end
    // ----------------------------------------------------------------
    // Expectation functions.
    // ----------------------------------------------------------------
    // Implemented bits of each register index; unused indices hold nothing.
    function automatic logic [7:0] mask_of(input int i);
        case (i)
            3: return pixel_datapath_pkg::MASK_ROT_FUNC;
            4: return pixel_datapath_pkg::MASK_PLANE_SEL;
            5: return pixel_datapath_pkg::MASK_MODE;
            8: return 8'hFF;
            default: return (i < 9) ? pixel_datapath_pkg::MASK_NIBBLE : 8'h00;
        endcase
    endfunction
    // Right rotation of a host byte.
    function automatic logic [7:0] rotr(input logic [7:0] d, input logic [2:0] n);
        return (d >> n) | (d << (8 - n));
    endfunction
    // Expected four plane bytes written in one lane.
    function automatic logic [31:0] exp_write(input logic [7:0] d, input logic [31:0] l);
        logic [7:0] r, m, v, lp;
        logic [31:0] res;
        r = rotr(d, regs[3][2:0]);
        m = (regs[5][1:0] == 2'h3) ? (r & regs[8]) : regs[8];
        for (int p = 0; p < 4; p++) begin
            lp = l[p*8 +: 8];
            case (regs[5][1:0])
                2'h0: v = regs[1][p] ? {8{regs[0][p]}} : r;
                2'h1: v = lp;
                2'h2: v = {8{d[p]}};
                default: v = {8{regs[0][p]}};
            endcase
            if (regs[5][1:0] != 2'h1) begin
                case (regs[3][4:3])
                    2'h1: v = v & lp;
                    2'h2: v = v | lp;
                    2'h3: v = v ^ lp;
                    default: v = v;
                endcase
            end
            res[p*8 +: 8] = (v & m) | (lp & ~m);
        end
        return res;
    endfunction
    // Expected read byte of one lane.
    function automatic logic [7:0] exp_read(input logic [31:0] l);
        logic [1:0] pl;
        logic [7:0] res;
        pl = quad ? addr : (regs[5][4] ? {regs[4][1], addr[0]} : regs[4][1:0]);
        res = l[pl*8 +: 8];
        if (regs[5][3]) begin
            for (int i = 0; i < 8; i++) begin
                res[i] = (((regs[2][3:0] ^ {l[24+i], l[16+i], l[8+i], l[i]})
                    & regs[7][3:0]) == 4'h0);
            end
        end
        return res;
    endfunction
    // ----------------------------------------------------------------
    // Bus tasks; each strobe is a one-cycle pulse.
    // ----------------------------------------------------------------
    task automatic io_write(input logic p, input logic [7:0] d);
        @(posedge core_clk_in) #1;
        io_port = p;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge core_clk_in) #1;
        io_wr = 1'b0;
    endtask
    task automatic io_read(input logic p);
        @(posedge core_clk_in) #1;
        io_port = p;
        io_rd = 1'b1;
        @(posedge core_clk_in) #1;
        io_rd = 1'b0;
    endtask
    // One memory cycle; fill selects a model preload instead of a host access.
    task automatic mem_cycle(input logic wr, input logic fill);
        @(posedge core_clk_in) #1;
        fill_en = fill;
        mem_wr = wr & ~fill;
        mem_rd = ~wr & ~fill;
        @(posedge core_clk_in) #1;
        fill_en = 1'b0;
        mem_wr = 1'b0;
        mem_rd = 1'b0;
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Main sequence.
    // ----------------------------------------------------------------
    initial begin
        repeat (6) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        // Reset values, readback masks and unused indices.
        for (int i = 0; i < 16; i++) begin
            io_write(1'b0, 8'(i));
            io_read(1'b1);
            `CHK("reset value", pixel_datapath_pkg::REG_RESET, io_rdata)
            v = 8'($random(seed));
            io_write(1'b1, v);
            regs[i] = v & mask_of(i);
            io_read(1'b1);
            `CHK("register", regs[i], io_rdata)
            io_read(1'b0);
            `CHK("index", 8'(i), io_rdata)
        end
        // Random datapath traffic; loop index sweeps write modes and functions.
        for (int i = 0; i < 64; i++) begin
            lat = {32'($random(seed)), 32'($random(seed))};
            mem_cycle(1'b0, 1'b1);
            for (int r = 0; r < 9; r++) begin
                v = 8'($random(seed));
                if (r == 3) v[4:3] = 2'(i >> 2);
                if (r == 5) v[1:0] = 2'(i);
                io_write(1'b0, 8'(r));
                io_write(1'b1, v);
                regs[r] = v & mask_of(r);
            end
            crtc_idx = ($random(seed) & 3) ? 8'h22 : 8'($random(seed));
            addr = 2'($random(seed));
            quad = (($random(seed) & 3) == 0);
            mem_cycle(1'b0, 1'b0);
            `CHK("read", {exp_read(lat[63:32]), exp_read(lat[31:0])}, hrdata)
            @(posedge core_clk_in) #1;
            `CHK("readback", (crtc_idx == 8'h22) ? lat[regs[4][1:0]*8 +: 8] : 8'h00, crtc_rdata)
            hwdata = 16'($random(seed));
            mem_cycle(1'b1, 1'b0);
            `CHK("plane strobe", 1'b1, pwr)
            `CHK("plane data", {exp_write(hwdata[15:8], lat[63:32]), exp_write(hwdata[7:0], lat[31:0])}, pwdata)
            @(posedge core_clk_in) #1;
            `CHK("plane strobe end", 1'b0, pwr)
        end
        // Protected writes leave both index and data untouched.
        io_write(1'b0, {4'h0, pixel_datapath_pkg::IDX_BIT_MASK});
        protect = 1'b1;
        io_write(1'b1, ~regs[8]);
        io_write(1'b0, 8'h02);
        protect = 1'b0;
        io_read(1'b1);
        `CHK("protected data", regs[8], io_rdata)
        io_read(1'b0);
        `CHK("protected index", 8'h08, io_rdata)
        end_of_test();
    end
endmodule
`undef CHK
`default_nettype wire
